// [rtl/cfda_pkg.sv]
package cfda_pkg;
   // widths
   localparam int DW = 10;                  // tap sample width
   localparam int EW = 10;                  // error signal width
   localparam int AW = 12;                  // apb address width
   localparam logic [9:0] ERR_MAX = 10'h3ff;   // full-scale error

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h4a;
   localparam logic [7:0] IDX_STAT = 8'h4b;
   localparam logic [AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [AW-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

   // control register fields
   localparam int C_PAL   = 0;              // 1: pal, 0: ntsc
   localparam int C_YGAIN = 1;              // luma error gain bit
   localparam int C_CGAIN = 2;              // chroma error gain bit
   localparam int C_RATE  = 3;              // rate compensation, 2 bits
   localparam int C_THR   = 5;              // adaption threshold, 2 bits
   localparam int C_FBEN  = 7;              // 3-line to 2-line fallback enable
   localparam int C_QUICK = 8;              // quick selection
   localparam int C_MODE  = 9;              // comb switch mode, 2 bits
   localparam int C_THREE = 11;             // 1: 3-line comb configured
   localparam logic [31:0] CTRL_RST  = 32'h0000_0880;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0fff;

   // comb switch modes
   localparam logic [1:0] MODE_BEST  = 2'h0;
   localparam logic [1:0] MODE_LOWER = 2'h1;
   localparam logic [1:0] MODE_FIXED = 2'h2;
   localparam logic [1:0] MODE_PAL2  = 2'h3;

   // per-pixel comb choice
   typedef enum logic [1:0] {
      CH_THREE  = 2'h0,
      CH_UPPER  = 2'h1,
      CH_LOWER  = 2'h2,
      CH_SIMPLE = 2'h3
   } cfda_choice_type;

   // correlation thresholds as a share of the summed full-scale error
   localparam int FULL_SCALE = 3 * 1023;
   localparam int PCT0 = 5;
   localparam int PCT1 = 15;
   localparam int PCT2 = 25;
   localparam int PCT3 = 50;
   localparam logic [12:0] THR0 = 13'(FULL_SCALE * PCT0 / 100);
   localparam logic [12:0] THR1 = 13'(FULL_SCALE * PCT1 / 100);
   localparam logic [12:0] THR2 = 13'(FULL_SCALE * PCT2 / 100);
   localparam logic [12:0] THR3 = 13'(FULL_SCALE * PCT3 / 100);

   // demodulator phase step per pixel for each rate setting
   localparam logic [1:0] STEP0 = 2'h1;     // 13.5 MHz preset
   localparam logic [1:0] STEP1 = 2'h3;
   localparam logic [1:0] STEP2 = 2'h2;
   localparam logic [1:0] STEP3 = 2'h1;
endpackage

// [rtl/cfda_core.sv]
`timescale 1ns/1ps
// Functional notes
// - lower luma error is rectified 0H minus 1H
// - upper luma error pairs 1H/2H ntsc, 0H/2H pal
// - luma gain doubles errors with saturation
// - each tap split into low and high band
// - high bands demodulated into I and Q
// - lower pairs 0H/1H, upper depends on standard
// - chroma gain doubles saturation errors, limited
// - rate field picks alternate demodulator default
// - correlation is rectified upper minus lower error total
// - threshold field picks 5/15/25/50 percent
// - ntsc falls from 3-line to 2-line to simple
// - fallback disable sends failing 3-line to simple
// - choice independent of mix value K
// - no 3-line to 2-line fallback in pal
// - quick bit low filters the per-pixel choice
// - switch mode ignored unless 3-line comb chosen
// - mode 00 picks best of three, ntsc only
// - mode 01 falls back to lower 2-line only
// - mode 10 fixed 3-line, larger error set
// - mode 11 picks better 3-line comb, pal only
// - choice readable as status at index 4Bh
// - forwarded error set matches the active comb; pal outside mode 10 forwards lower set
module cfda_core (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // comb filter taps, one pixel per clock
   input  wire logic [9:0]  undelayed_tap,
   input  wire logic [9:0]  one_line_tap,
   input  wire logic [9:0]  two_line_tap,
   // toward comb datapath and mix lookup table
   output logic      [1:0]  per_pixel_filter_choice,
   output logic      [9:0]  fwd_luma_error,
   output logic      [9:0]  fwd_saturation_error,
   output logic      [9:0]  fwd_hue_error
);

   // whole state of the block
   typedef struct packed {
      logic [31:0]      ctrl;     // control register
      logic [31:0]      rdata;    // read data for access phase
      logic [1:0]       phase;    // demodulator phase
      logic [2:0][9:0]  prev;     // previous sample per tap
      logic [2:0][9:0]  low;      // low band per tap
      logic [2:0][10:0] iq_i;     // in-phase per tap, signed
      logic [2:0][10:0] iq_q;     // quadrature per tap, signed
      logic [9:0]       ll;       // lower_luma_error
      logic [9:0]       ul;       // upper_luma_error
      logic [9:0]       ls;       // lower_saturation_error
      logic [9:0]       us;       // upper_saturation_error
      logic [9:0]       lh;       // lower_hue_error
      logic [9:0]       uh;       // upper_hue_error
      logic [1:0]       raw;      // unfiltered choice
      logic [1:0]       choice;   // per_pixel_filter_choice
      logic [9:0]       fl;       // forwarded luma error
      logic [9:0]       fs;       // forwarded saturation error
      logic [9:0]       fh;       // forwarded hue error
   } cfda_state_type;

   cfda_state_type s_q;           // registered state
   cfda_state_type s_d;           // next state

   // control fields
   logic        pal;
   logic        ygain;
   logic        cgain;
   logic [1:0]  rate;
   logic [1:0]  thr_sel;
   logic        fb_en;
   logic        quick;
   logic [1:0]  mode;
   logic        three;

   // combinational helpers
   logic [2:0][9:0]  tap;         // taps as an array
   logic [2:0][10:0] hb;          // high band per tap, signed
   logic [2:0][11:0] mag;         // magnitude per tap
   logic [1:0]       step;        // phase step
   logic [1:0]       ua;          // first tap of upper pair
   logic [12:0]      tu;          // upper error total
   logic [12:0]      tl;          // lower error total
   logic [12:0]      cdiff;       // correlation difference
   logic [12:0]      thr;         // selected threshold
   logic             fail;        // 3-line comb judged failing
   logic             fb;          // fallback really allowed
   logic             up_small;    // upper pair is the better one
   logic             setup;       // apb setup phase
   logic             acc;         // apb access phase
   logic             hit_ctrl;
   logic             hit_stat;

   assign pal     = s_q.ctrl[cfda_pkg::C_PAL];
   assign ygain   = s_q.ctrl[cfda_pkg::C_YGAIN];
   assign cgain   = s_q.ctrl[cfda_pkg::C_CGAIN];
   assign rate    = s_q.ctrl[cfda_pkg::C_RATE +: 2];
   assign thr_sel = s_q.ctrl[cfda_pkg::C_THR +: 2];
   assign fb_en   = s_q.ctrl[cfda_pkg::C_FBEN];
   assign quick   = s_q.ctrl[cfda_pkg::C_QUICK];
   assign mode    = s_q.ctrl[cfda_pkg::C_MODE +: 2];
   assign three   = s_q.ctrl[cfda_pkg::C_THREE];

   assign tap[0] = undelayed_tap;
   assign tap[1] = one_line_tap;
   assign tap[2] = two_line_tap;

   // unsigned distance of two values
   function automatic logic [12:0] adiff(input logic [12:0] a, input logic [12:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   // clip a wide error to full scale
   function automatic logic [9:0] sat10(input logic [12:0] x);
      return (x > 13'h03ff) ? cfda_pkg::ERR_MAX : x[9:0];
   endfunction

   // optional doubling; clipping keeps the top code instead of wrapping
   function automatic logic [9:0] dbl(input logic [9:0] x, input logic g);
      if (!g) begin
         return x;
      end
      return x[9] ? cfda_pkg::ERR_MAX : {x[8:0], 1'b0};
   endfunction

   // offset binary keeps the ordering of a signed value
   function automatic logic [12:0] ob(input logic [10:0] x);
      return {2'h0, ~x[10], x[9:0]};
   endfunction

   // absolute value of a signed sample
   function automatic logic [11:0] abs11(input logic [10:0] x);
      logic [10:0] n;
      n = x[10] ? 11'(-x) : x;
      return {1'b0, n};
   endfunction

   // bus decode
   assign setup    = psel & ~penable;
   assign acc      = psel & penable;
   assign hit_ctrl = paddr == cfda_pkg::ADDR_CTRL;
   assign hit_stat = paddr == cfda_pkg::ADDR_STAT;

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = acc & ~(hit_ctrl | hit_stat);
   assign prdata  = s_q.rdata;

   // outputs straight from state
   assign per_pixel_filter_choice = s_q.choice;
   assign fwd_luma_error          = s_q.fl;
   assign fwd_saturation_error    = s_q.fs;
   assign fwd_hue_error           = s_q.fh;

   // next-state logic for bus, taps, errors and choice
   always_comb begin
      s_d = s_q;
      hb  = '0;
      mag = '0;

      // register writes, byte lanes honoured
      if (acc && pwrite && hit_ctrl) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               s_d.ctrl[8*b +: 8] = pwdata[8*b +: 8];
            end
         end
         s_d.ctrl = s_d.ctrl & cfda_pkg::CTRL_MASK;
      end

      // read data caught in setup, shown in access
      if (setup && !pwrite) begin
         if (hit_ctrl) begin
            s_d.rdata = s_q.ctrl;
         end else if (hit_stat) begin
            s_d.rdata = {30'h0, s_q.choice};
         end else begin
            s_d.rdata = 32'h0;
         end
      end

      // demodulator phase advance per rate setting
      case (rate)
         2'h0:    step = cfda_pkg::STEP0;
         2'h1:    step = cfda_pkg::STEP1;
         2'h2:    step = cfda_pkg::STEP2;
         default: step = cfda_pkg::STEP3;
      endcase
      s_d.phase = s_q.phase + step;

      // band split and demodulation per tap
      for (int t = 0; t < 3; t++) begin
         s_d.prev[t] = tap[t];
         s_d.low[t]  = 10'(({1'b0, tap[t]} + {1'b0, s_q.prev[t]}) >> 1);
         hb[t]       = {1'b0, tap[t]} - {1'b0, s_q.prev[t]};
         case (s_q.phase)
            2'h0:    s_d.iq_i[t] = hb[t];
            2'h1:    s_d.iq_q[t] = hb[t];
            2'h2:    s_d.iq_i[t] = 11'(-hb[t]);
            default: s_d.iq_q[t] = 11'(-hb[t]);
         endcase
         mag[t] = abs11(s_q.iq_i[t]) + abs11(s_q.iq_q[t]);
      end

      // upper pair starts at 1H in ntsc, 0H in pal
      ua = pal ? 2'd0 : 2'd1;

      // luma errors
      s_d.ll = dbl(sat10(adiff({3'h0, s_q.low[0]}, {3'h0, s_q.low[1]})), ygain);
      s_d.ul = dbl(sat10(adiff({3'h0, s_q.low[ua]}, {3'h0, s_q.low[2]})), ygain);

      // saturation errors from magnitudes
      s_d.ls = dbl(sat10(adiff({1'b0, mag[0]}, {1'b0, mag[1]}) >> 1), cgain);
      s_d.us = dbl(sat10(adiff({1'b0, mag[ua]}, {1'b0, mag[2]}) >> 1), cgain);

      // hue error: vector distance beyond the magnitude change
      s_d.lh = sat10((adiff(ob(s_q.iq_i[0]), ob(s_q.iq_i[1]))
                    + adiff(ob(s_q.iq_q[0]), ob(s_q.iq_q[1]))
                    - adiff({1'b0, mag[0]}, {1'b0, mag[1]})) >> 1);
      s_d.uh = sat10((adiff(ob(s_q.iq_i[ua]), ob(s_q.iq_i[2]))
                    + adiff(ob(s_q.iq_q[ua]), ob(s_q.iq_q[2]))
                    - adiff({1'b0, mag[ua]}, {1'b0, mag[2]})) >> 1);

      // correlation from registered error sets
      tu    = {3'h0, s_q.ul} + {3'h0, s_q.us} + {3'h0, s_q.uh};
      tl    = {3'h0, s_q.ll} + {3'h0, s_q.ls} + {3'h0, s_q.lh};
      cdiff = adiff(tu, tl);
      case (thr_sel)
         2'h0:    thr = cfda_pkg::THR0;
         2'h1:    thr = cfda_pkg::THR1;
         2'h2:    thr = cfda_pkg::THR2;
         default: thr = cfda_pkg::THR3;
      endcase
      fail     = cdiff > thr;
      up_small = tu < tl;
      // pal never gets the 2-line fallback
      fb       = fb_en & ~pal;

      // raw choice; no mix value enters, so K cannot steer it
      if (!three) begin
         s_d.raw = cfda_pkg::CH_LOWER;
      end else begin
         case (mode)
            cfda_pkg::MODE_BEST: begin
               if (pal || !fail) begin
                  s_d.raw = cfda_pkg::CH_THREE;
               end else if (!fb) begin
                  s_d.raw = cfda_pkg::CH_SIMPLE;
               end else if ((up_small ? tu : tl) > thr) begin
                  s_d.raw = cfda_pkg::CH_SIMPLE;
               end else begin
                  s_d.raw = up_small ? cfda_pkg::CH_UPPER : cfda_pkg::CH_LOWER;
               end
            end
            cfda_pkg::MODE_LOWER: begin
               if (!fail) begin
                  s_d.raw = cfda_pkg::CH_THREE;
               end else begin
                  s_d.raw = fb ? cfda_pkg::CH_LOWER : cfda_pkg::CH_SIMPLE;
               end
            end
            cfda_pkg::MODE_FIXED: begin
               s_d.raw = cfda_pkg::CH_THREE;
            end
            default: begin
               // in pal, code 01 marks the second 3-line comb
               if (pal && up_small) begin
                  s_d.raw = cfda_pkg::CH_UPPER;
               end else begin
                  s_d.raw = cfda_pkg::CH_THREE;
               end
            end
         endcase
      end

      // filtering: unless quick is set, only a choice seen twice running is taken
      if (quick || s_d.raw == s_q.raw) begin
         s_d.choice = s_d.raw;
      end

      // error set matching the comb that will run; pal outside MODE_FIXED takes the lower set
      if (pal && mode != cfda_pkg::MODE_FIXED) begin
         s_d.fl = s_q.ll;
         s_d.fs = s_q.ls;
         s_d.fh = s_q.lh;
      end else if ((s_d.choice == cfda_pkg::CH_THREE && !up_small)
                   || s_d.choice == cfda_pkg::CH_UPPER) begin
         s_d.fl = s_q.ul;
         s_d.fs = s_q.us;
         s_d.fh = s_q.uh;
      end else begin
         s_d.fl = s_q.ll;
         s_d.fs = s_q.ls;
         s_d.fh = s_q.lh;
      end
   end

   // one register stage per pixel clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q      <= '0;
         s_q.ctrl <= cfda_pkg::CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_lower_luma_diff: assert property (
      !$past(ygain) |-> s_q.ll == 10'(adiff({3'h0, $past(s_q.low[0])},
                                             {3'h0, $past(s_q.low[1])})))
      else $error("lower luma error wrong");

   a_upper_luma_pair: assert property (
      $past(pal) && !$past(ygain) |-> s_q.ul == 10'(adiff({3'h0, $past(s_q.low[0])},
                                                          {3'h0, $past(s_q.low[2])})))
      else $error("upper luma error pair wrong");

   a_luma_gain_sat: assert property (
      $past(ygain) |-> (s_q.ll[0] == 1'b0 || s_q.ll == cfda_pkg::ERR_MAX))
      else $error("luma gain not doubled or clipped");

   a_chroma_gain_sat: assert property (
      $past(cgain) |-> (s_q.us[0] == 1'b0 || s_q.us == cfda_pkg::ERR_MAX))
      else $error("chroma gain not doubled or clipped");

   a_two_line_fixed: assert property (
      (!three) [*3] |=> s_q.choice == cfda_pkg::CH_LOWER)
      else $error("2-line comb adapted");

   a_fixed_three: assert property (
      (three && mode == cfda_pkg::MODE_FIXED) [*3] |=> s_q.choice == cfda_pkg::CH_THREE)
      else $error("fixed 3-line comb adapted");

   a_pal_no_upper: assert property (
      (pal && mode != cfda_pkg::MODE_PAL2) [*3] |=> s_q.choice != cfda_pkg::CH_UPPER)
      else $error("pal fell back to 2-line comb");

   a_filter_stable: assert property (
      !$past(quick) && $changed(s_q.choice) |-> s_q.choice == s_q.raw
                                             && $past(s_q.raw) == s_q.raw)
      else $error("filtered choice switched early");

   a_quick_follow: assert property (
      $past(quick) |-> s_q.choice == s_q.raw)
      else $error("quick choice not followed");

   a_status_read: assert property (
      setup && !pwrite && hit_stat |=> prdata == {30'h0, $past(s_q.choice)})
      else $error("status read wrong");

   a_upper_forward: assert property (
      !$past(pal) && s_q.choice == cfda_pkg::CH_UPPER |-> s_q.fl == $past(s_q.ul))
      else $error("upper error set not forwarded");

   c_upper_pick: cover property (s_q.choice == cfda_pkg::CH_UPPER && !pal);
   c_lower_pick: cover property (s_q.choice == cfda_pkg::CH_LOWER && three);
   c_simple_pick: cover property (s_q.choice == cfda_pkg::CH_SIMPLE);
   c_pal_second: cover property (pal && s_q.choice == cfda_pkg::CH_UPPER);

endmodule

// [verification/cfda_tap_src.sv]
`timescale 1ns/1ps
// far-side model: comb datapath handing three line taps per pixel
module cfda_tap_src (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // wanted level on each line tap
   input  wire logic [9:0] lvl_u,
   input  wire logic [9:0] lvl_o,
   input  wire logic [9:0] lvl_t,
   // taps toward the detector
   output logic      [9:0] undelayed_tap,
   output logic      [9:0] one_line_tap,
   output logic      [9:0] two_line_tap
);
   // taps change only just after an edge, one pixel per clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // blanking level while the pipe is held
         undelayed_tap <= 10'h000;
         one_line_tap  <= 10'h000;
         two_line_tap  <= 10'h000;
      end else begin
         // taps arrive already line-aligned; each is registered once here
         // undelayed, one-line and two-line taps in step
         undelayed_tap <= lvl_u;
         one_line_tap  <= lvl_o;
         two_line_tap  <= lvl_t;
      end
   end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   // clock, reset and apb
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr, serr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   // line levels and taps
   logic [9:0]  lu, lo, lt, tu, to1, tt;
   // outputs under test
   logic [1:0]  choice;
   logic [9:0]  f_luma, f_sat, f_hue;
   // score keeping and hang guard
   int          mismatches, check_count, cycles;
   // correlation thresholds per field value
   int          thr [4];
   // directed rows: undelayed, one-line, two-line, ctrl
   int          tbl [14][4] = '{
      '{500, 500, 500, 'h880},
      '{900, 100, 100, 'h880},
      '{100, 100, 900, 'h880},
      '{0, 400, 1000, 'h880},
      '{0, 400, 1000, 'h8a0},
      '{900, 100, 100, 'h800},
      '{100, 100, 900, 'ha80},
      '{900, 100, 100, 'hc80},
      '{900, 100, 100, 'he80},
      '{100, 100, 900, 'h881},
      '{100, 100, 900, 'hc81},
      '{900, 100, 100, 'h080},
      '{700, 100, 100, 'hc82},
      '{900, 100, 900, 'he81}};

   cfda_tap_src u_src (.clk(clk), .nrst(nrst), .lvl_u(lu), .lvl_o(lo), .lvl_t(lt),
      .undelayed_tap(tu), .one_line_tap(to1), .two_line_tap(tt));

   cfda_core DUT (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .undelayed_tap(tu), .one_line_tap(to1), .two_line_tap(tt),
      .per_pixel_filter_choice(choice), .fwd_luma_error(f_luma),
      .fwd_saturation_error(f_sat), .fwd_hue_error(f_hue));

   // free-running pixel clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // hang guard: a stuck handshake ends the run as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         final_report();
      end
   end

   // verdict and end of run
   task automatic final_report();
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // one comparison, four-state exact
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // one apb transfer; request held until pready seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd   = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup is not in this time step
      @(posedge clk);
   endtask

   // rectified difference
   function automatic int absd(input int a, input int b);
      return (a > b) ? a - b : b - a;
   endfunction

   // doubled and clipped at full scale
   function automatic int dbl(input int a);
      return (2 * a > int'(cfda_pkg::ERR_MAX)) ? int'(cfda_pkg::ERR_MAX) : 2 * a;
   endfunction

   // reference: choice and forwarded luma for steady line levels
   function automatic void model(input int u, o, t, input logic [31:0] c,
                                 output int ch, output int fw, output bit amb);
      int lo_e, up_e, th, mn;
      lo_e = absd(u, o);
      up_e = c[0] ? absd(u, t) : absd(o, t);
      if (c[1]) begin
         lo_e = dbl(lo_e);
         up_e = dbl(up_e);
      end
      th = thr[c[6:5]];
      mn = (up_e < lo_e) ? up_e : lo_e;
      // a tie at the threshold may go either way
      amb = (absd(up_e, lo_e) == th) || (mn == th);
      ch = 0;
      if (!c[11])
         ch = 2;
      else if (c[0] && c[10:9] == 2'h3)
         ch = (up_e < lo_e) ? 1 : 0;
      else if (absd(up_e, lo_e) > th) begin
         if (c[10:9] == 2'h0 && !c[0])
            ch = (c[7] && mn <= th) ? ((up_e < lo_e) ? 1 : 2) : 3;
         if (c[10:9] == 2'h1)
            ch = (c[7] && !c[0]) ? 2 : 3;
      end
      fw = (ch == 1 && !c[0]) ? up_e : lo_e;
      if (ch == 0 && (!c[0] || c[10:9] == 2'h2))
         fw = (up_e > lo_e) ? up_e : lo_e;
   endfunction

   // program ctrl, hold levels, compare settled outputs and status
   task automatic run_case(input int u, o, t, input logic [31:0] c);
      int  ch, fw;
      bit  amb;
      apb(1'b1, cfda_pkg::ADDR_CTRL, c);
      lu <= 10'(u);
      lo <= 10'(o);
      lt <= 10'(t);
      // tap register, three pipe stages and the choice filter
      repeat (10) @(posedge clk);
      model(u, o, t, c, ch, fw, amb);
      if (!amb) begin
         chk("choice", 32'(ch), 32'(choice));
         chk("fwd_luma", 32'(fw), 32'(f_luma));
         chk("fwd_sat", 32'h0, 32'(f_sat));
         chk("fwd_hue", 32'h0, 32'(f_hue));
         apb(1'b0, cfda_pkg::ADDR_STAT, 32'h0);
         chk("status", 32'(ch), rd);
      end
   endtask

   // main sequence
   initial begin
      logic [31:0] c;
      thr = '{int'(cfda_pkg::THR0), int'(cfda_pkg::THR1),
              int'(cfda_pkg::THR2), int'(cfda_pkg::THR3)};
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      lu = 10'h000;
      lo = 10'h000;
      lt = 10'h000;
      mismatches = 0;
      check_count = 0;
      cycles = 0;
      void'($urandom(40758));
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      // control register reset value, mask and unmapped place
      apb(1'b0, cfda_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl_reset", cfda_pkg::CTRL_RST, rd);
      chk("pready", 32'h1, 32'(pready));
      apb(1'b1, cfda_pkg::ADDR_CTRL, 32'hffff_ffff);
      apb(1'b0, cfda_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl_mask", cfda_pkg::CTRL_MASK, rd);
      apb(1'b1, 12'h000, 32'h0000_0001);
      chk("slverr_wr", 32'h1, 32'(serr));
      apb(1'b0, 12'h000, 32'h0);
      chk("slverr_rd", 32'h1, 32'(serr));
      chk("unmapped_rd", 32'h0, rd);
      // directed rows, one per adaption situation
      for (int i = 0; i < 14; i++) begin
         run_case(tbl[i][0], tbl[i][1], tbl[i][2], 32'(tbl[i][3]));
      end
      // random levels and settings over every mode
      repeat (40) begin
         c = $urandom() & 32'h0000_0fff;
         run_case($urandom() % 1024, $urandom() % 1024, $urandom() % 1024, c);
      end
      final_report();
   end
endmodule
